// [shared/mct_cfg.svh]
`ifndef MCT_CFG_SVH
`define MCT_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MCT_OFS_CTRL      8'h00
`define MCT_OFS_STATUS    8'h04
`define MCT_OFS_MC1_ID    8'h08
`define MCT_OFS_MC2_ID    8'h0C
`define MCT_OFS_MC2_DATA  8'h10
`define MCT_OFS_PULSE_LEN 8'h14
`define MCT_OFS_SYM_EN    8'h18
`define MCT_OFS_MREADS    8'h1C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MCT_CTRL_W        20
`define MCT_MC2_IDX_LSB   8
`define MCT_RST_CTRL      20'h00000
`define MCT_RST_PULSE_LEN 16'h0FA0
`define MCT_RST_SYM_EN    16'hFFFF
`define MCT_RST_MREADS    8'h01
`define MCT_IMPL_MASK     16'h03FF

// ----------------------------------------------------------------
// Code limits and symbology numbers
// ----------------------------------------------------------------
`define MCT_MAX_LEN       6'd50
`define MCT_CHR_MIN       8'd32
`define MCT_CHR_MAX       8'd137
`define MCT_SYM_PHARMA    4'h9
`define MCT_PHARMA_MIN    6'd6
`define MCT_TEACH_MREADS  8'd30

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCT_CLK_KHZ       25000
`define MCT_DEB_TIME_MS   10
`define MCT_DEB_CYCLES    (`MCT_DEB_TIME_MS * `MCT_CLK_KHZ)

`endif

// [shared/mct_pkg.sv]
package mct_pkg;

   // Teach-in sequence, Gray coded along the usual path
   typedef enum logic [1:0] {
      MCT_IDLE  = 2'b00,
      MCT_TEACH = 2'b01,
      MCT_CAPT  = 2'b11,
      MCT_SAVE  = 2'b10
   } mct_state_e;

   // Identity of a code: symbology and length
   typedef struct packed {
      logic [3:0] sym;
      logic [5:0] len;
   } mct_code_s;

   // Decoder character stream
   typedef struct packed {
      logic       start;
      logic [3:0] sym;
      logic       chr_vld;
      logic [7:0] chr;
      logic       done;
   } mct_dec_s;

   // Control register layout
   typedef struct packed {
      logic [3:0] beep_fn;
      logic [3:0] res2_fn;
      logic [3:0] res1_fn;
      logic       param_mode;
      logic       sens_assign;
      logic       cnt_rst;
      logic       pharma;
      logic       teach_static;
      logic       mc2_act;
      logic       filt_en;
      logic       cmp_en;
   } mct_ctrl_s;

   // Result function selector
   typedef enum logic [3:0] {
      MCT_FN_OFF    = 4'h0,
      MCT_FN_NOMATCH= 4'h1,
      MCT_FN_M1     = 4'h2,
      MCT_FN_MIS1   = 4'h3,
      MCT_FN_M2     = 4'h4,
      MCT_FN_MIS2   = 4'h5,
      MCT_FN_M1OR2  = 4'h6,
      MCT_FN_M1AND2 = 4'h7
   } mct_fn_e;

endpackage

// [hw/mct_debounce.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mct_cfg.svh"

module mct_debounce #(
   parameter int unsigned DEB_CYCLES = `MCT_DEB_CYCLES
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   // Raw switch pin
   input  wire logic pin,
   // Debounced level and edges
   output logic      level,
   output logic      ready,
   output logic      rise,
   output logic      fall
);

   typedef struct packed {
      logic        meta;
      logic        sync;
      logic        level;
      logic        ready;
      logic        rise;
      logic        fall;
      logic [23:0] cnt;
   } mct_deb_s;

   mct_deb_s q, d;

   // ----------------------------------------------------------------
   // Settling filter
   // ----------------------------------------------------------------
   always_comb begin
      d      = q;
      d.meta = pin;
      d.sync = q.meta;
      d.rise = 1'b0;
      d.fall = 1'b0;
      if (!q.ready) begin
         // Power-up: follow the pin until it has stayed put for a full period
         d.level = q.sync;
         if (q.sync != q.level) begin
            d.cnt = 24'h000000;
         end else if (q.cnt >= 24'(DEB_CYCLES - 1)) begin
            d.cnt   = 24'h000000;
            d.ready = 1'b1;
         end else begin
            d.cnt = q.cnt + 24'h000001;
         end
      end else if (q.sync == q.level) begin
         d.cnt = 24'h000000;
      end else if (q.cnt >= 24'(DEB_CYCLES - 1)) begin
         d.cnt   = 24'h000000;
         d.level = q.sync;
         d.rise  = q.sync;
         d.fall  = ~q.sync;
      end else begin
         d.cnt = q.cnt + 24'h000001;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign level = q.level;
   assign ready = q.ready;
   assign rise  = q.rise;
   assign fall  = q.fall;

endmodule
`default_nettype wire

// [hw/mct_code_cmp.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mct_cfg.svh"

module mct_code_cmp (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          ce,
   // Decoder stream and per-character equality
   input  wire mct_pkg::mct_dec_s  dec,
   input  wire logic          eq1,
   input  wire logic          eq2,
   // Stored identities
   input  wire mct_pkg::mct_code_s mc1,
   input  wire mct_pkg::mct_code_s mc2,
   // Position and verdict
   output logic [5:0]         idx,
   output logic               ovf,
   output logic               m1,
   output logic               m2
);

   typedef struct packed {
      logic [5:0] idx;
      logic       ovf;
      logic       eq1;
      logic       eq2;
   } mct_cmp_s;

   mct_cmp_s q, d;

   // ----------------------------------------------------------------
   // Running content comparison
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      if (dec.start) begin
         d = '{idx: 6'd0, ovf: 1'b0, eq1: 1'b1, eq2: 1'b1};
      end else if (dec.chr_vld) begin
         if (q.idx >= `MCT_MAX_LEN) begin
            d.ovf = 1'b1;
         end else begin
            d.idx = q.idx + 6'd1;
            d.eq1 = q.eq1 & eq1;
            d.eq2 = q.eq2 & eq2;
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // Type, length and content all equal
   assign idx = q.idx;
   assign ovf = q.ovf;
   assign m1  = q.eq1 & ~q.ovf & (dec.sym == mc1.sym) & (q.idx == mc1.len);
   assign m2  = q.eq2 & ~q.ovf & (dec.sym == mc2.sym) & (q.idx == mc2.len);

endmodule
`default_nettype wire

// [hw/mct_teach_ctrl.sv]
// Notes on behaviour
// - In reading mode every decoded code is compared with both match codes.
// - Output filter forwards only codes equal in type, length, content to active codes.
// - Match code holds up to 50 characters, each 32 to 137.
// - Only a symbology the decoder can evaluate becomes a match code.
// - Teach-in records symbology, length and content of match code 1.
// - Comparison enabled by the sensor input stays on until power-off.
// - Dynamic teach needs an enabled symbology and an external reading pulse.
// - After dynamic teach all previously enabled symbologies are still output.
// - Static teach uses the standard decoder and any implemented symbology.
// - Static teach starts its own reading pulse, ends it on capture.
// - After static teach only codes of match code 1 type and length pass.
// - Static teach temporarily requires 30 identical multiple reads.
// - Static teach without a capture leaves the code configuration unchanged.
// - Pharmaceutical variant accepts that code type only with six or more characters; the code checks this only in static teach, not in dynamic teach.
// - With counter-reset option each static teach clears the daily counters.
// - Configuration activation of comparison overrides the sensor input activation.
// - Match code 2 is set and enabled only through configuration registers.
// - Entering reading mode samples the switch and activates comparison then.
// - Every opening of the switch enters teach-in for match code 1.
// - A teach read beeps, ends the interval, keeps code in working memory.
// - Closing the switch after a teach read saves match code 1 permanently.
// - After saving, each result pulses the second result output for set length.
// - Closing without a teach read ends the interval, keeps old configuration.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "mct_cfg.svh"

module mct_teach_ctrl #(
   parameter int unsigned DEB_CYCLES = `MCT_DEB_CYCLES
) (
   // Clock, reset, clock enable
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               ce,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Sensor switch pin
   input  wire logic               sens_sw,
   // Decoder stream and external reading pulse
   input  wire mct_pkg::mct_dec_s  dec,
   input  wire logic               rd_trig,
   // Reading control towards the decoder
   output logic                    rd_int,
   output logic                    std_dec_sel,
   output logic [7:0]              mreads_req,
   output logic [15:0]             sym_lock,
   // Host forwarding and results
   output logic                    code_fwd,
   output logic                    res1,
   output logic                    res2,
   output logic                    beep,
   // Parameter store and counters
   output logic                    nv_save,
   output mct_pkg::mct_code_s      nv_code,
   input  wire logic [5:0]         nv_addr,
   output logic [7:0]              nv_chr,
   output logic                    cnt_clr
);

   typedef struct packed {
      mct_pkg::mct_state_e st;
      mct_pkg::mct_ctrl_s  ctrl;
      mct_pkg::mct_code_s  mc1;
      mct_pkg::mct_code_s  mc2;
      logic [15:0]         pulse_len;
      logic [15:0]         sym_en;
      logic [7:0]          mreads;
      logic                mc1_vld;
      logic                cmp_act;
      logic                lock;
      logic                sel;
      logic                bad;
      logic                init_done;
      logic                prev_param;
      logic                rd_static;
      logic                rd;
      logic                fwd;
      logic                save;
      logic                clr;
      logic [2:0][15:0]    rcnt;
      logic [2:0]          res;
      logic [31:0]         rdata;
   } mct_main_s;

   mct_main_s q, d;

   logic [7:0]  bank [0:1][0:49];
   logic [7:0]  mc2_mem [0:49];
   logic [5:0]  idx;
   logic        ovf;
   logic        m1;
   logic        m2;
   logic        eq1;
   logic        eq2;
   logic        sw_level;
   logic        sw_ready;
   logic        sw_rise;
   logic        sw_fall;
   logic [2:0]  fire;
   logic        cmp_eff;
   logic        m1a;
   logic        m2a;
   logic        teach_wr;
   logic        mc2_wr;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [3:0] reg_dec(input logic [7:0] a);
      case (a)
         `MCT_OFS_CTRL:      reg_dec = 4'h1;
         `MCT_OFS_STATUS:    reg_dec = 4'h2;
         `MCT_OFS_MC1_ID:    reg_dec = 4'h3;
         `MCT_OFS_MC2_ID:    reg_dec = 4'h4;
         `MCT_OFS_MC2_DATA:  reg_dec = 4'h5;
         `MCT_OFS_PULSE_LEN: reg_dec = 4'h6;
         `MCT_OFS_SYM_EN:    reg_dec = 4'h7;
         `MCT_OFS_MREADS:    reg_dec = 4'h8;
         default:            reg_dec = 4'h0;
      endcase
   endfunction

   function automatic logic res_fn(input logic [3:0] fn, input logic a, input logic b, input logic b_on);
      case (mct_pkg::mct_fn_e'(fn))
         mct_pkg::MCT_FN_NOMATCH: res_fn = ~a & ~(b & b_on);
         mct_pkg::MCT_FN_M1:      res_fn = a;
         mct_pkg::MCT_FN_MIS1:    res_fn = ~a;
         mct_pkg::MCT_FN_M2:      res_fn = b_on & b;
         mct_pkg::MCT_FN_MIS2:    res_fn = b_on & ~b;
         mct_pkg::MCT_FN_M1OR2:   res_fn = a | (b_on & b);
         mct_pkg::MCT_FN_M1AND2:  res_fn = b_on & a & b;
         default:                 res_fn = 1'b0;
      endcase
   endfunction

   function automatic logic chr_ok(input logic [7:0] c);
      chr_ok = (c >= `MCT_CHR_MIN) && (c <= `MCT_CHR_MAX);
   endfunction

   // ----------------------------------------------------------------
   // Switch conditioning and code comparison
   // ----------------------------------------------------------------
   mct_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pin     (sens_sw),
      .level   (sw_level),
      .ready   (sw_ready),
      .rise    (sw_rise),
      .fall    (sw_fall)
   );

   mct_code_cmp u_cmp (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .dec     (dec),
      .eq1     (eq1),
      .eq2     (eq2),
      .mc1     (q.mc1),
      .mc2     (q.mc2),
      .idx     (idx),
      .ovf     (ovf),
      .m1      (m1),
      .m2      (m2)
   );

   // Per-character equality against both stored codes
   assign eq1 = (idx < `MCT_MAX_LEN) && (bank[q.sel][idx] == dec.chr);
   assign eq2 = (idx < `MCT_MAX_LEN) && (mc2_mem[idx] == dec.chr);

   assign cmp_eff = q.cmp_act | q.ctrl.cmp_en;
   assign m1a     = m1 & q.mc1_vld;
   assign m2a     = m2 & q.ctrl.mc2_act;

   // Result functions for result 1, result 2 and beeper
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_fire
         logic [3:0] fn;
         assign fn = (gi == 0) ? q.ctrl.res1_fn : (gi == 1) ? q.ctrl.res2_fn : q.ctrl.beep_fn;
         assign fire[gi] = res_fn(fn, m1a, m2a, q.ctrl.mc2_act);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic       rd_acc;
      logic       wr_acc;
      logic       sym_ok;
      logic       teach_ok;
      logic       reading;
      logic       lock_ok;
      logic [2:0] load;
      logic [15:0] impl;
      rd_acc   = psel & ~penable & ~pwrite;
      wr_acc   = psel & penable & pwrite;
      impl     = `MCT_IMPL_MASK;
      reading  = (q.st == mct_pkg::MCT_IDLE) & ~q.ctrl.param_mode;
      load     = 3'b000;
      sym_ok   = 1'b0;
      teach_ok = 1'b0;
      lock_ok  = 1'b0;
      d        = q;
      d.fwd    = 1'b0;
      d.save   = 1'b0;
      d.clr    = 1'b0;
      d.prev_param = q.ctrl.param_mode;

      // Register writes
      if (wr_acc) begin
         case (reg_dec(paddr))
            4'h1:    d.ctrl      = mct_pkg::mct_ctrl_s'(pwdata[`MCT_CTRL_W-1:0]);
            4'h4:    d.mc2       = mct_pkg::mct_code_s'(pwdata[9:0]);
            4'h6:    d.pulse_len = pwdata[15:0];
            4'h7:    d.sym_en    = pwdata[15:0];
            4'h8:    d.mreads    = pwdata[7:0];
            default: d.rdata     = q.rdata;
         endcase
      end

      // Read data captured in the setup phase
      if (rd_acc) begin
         case (reg_dec(paddr))
            4'h1:    d.rdata = {12'h000, q.ctrl};
            4'h2:    d.rdata = {24'h000000, q.mc1_vld, q.lock, sw_level, q.rd, cmp_eff, q.cmp_act, q.st};
            4'h3:    d.rdata = {22'h000000, q.mc1};
            4'h4:    d.rdata = {22'h000000, q.mc2};
            4'h6:    d.rdata = {16'h0000, q.pulse_len};
            4'h7:    d.rdata = {16'h0000, q.sym_en};
            4'h8:    d.rdata = {24'h000000, q.mreads};
            default: d.rdata = 32'h00000000;
         endcase
      end

      // Switch sampled on entering reading mode
      if ((sw_ready && !q.init_done) || (q.prev_param && !q.ctrl.param_mode)) begin
         d.init_done = 1'b1;
         if (sw_level && q.ctrl.sens_assign) begin
            d.cmp_act = 1'b1;
         end
      end

      // Bad character flag for the teach buffer
      if (dec.start) begin
         d.bad = 1'b0;
      end
      if (dec.chr_vld && !chr_ok(dec.chr)) begin
         d.bad = 1'b1;
      end

      // Acceptance of a taught code
      sym_ok   = q.ctrl.teach_static ? impl[dec.sym] : q.sym_en[dec.sym] & impl[dec.sym];
      teach_ok = dec.done & sym_ok & ~q.bad & ~ovf & (idx != 6'd0) & q.rd
               & ~(q.ctrl.teach_static & q.ctrl.pharma & (dec.sym == `MCT_SYM_PHARMA)
                   & (idx < `MCT_PHARMA_MIN));

      // Teach-in sequence
      case (q.st)
         mct_pkg::MCT_IDLE: begin
            if (sw_fall && q.ctrl.sens_assign && !q.ctrl.param_mode) begin
               d.st        = mct_pkg::MCT_TEACH;
               d.rd_static = q.ctrl.teach_static;
            end
         end
         mct_pkg::MCT_TEACH: begin
            if (sw_rise) begin
               d.st        = mct_pkg::MCT_IDLE;
               d.rd_static = 1'b0;
            end else if (teach_ok) begin
               d.st        = mct_pkg::MCT_CAPT;
               d.sel       = ~q.sel;
               d.mc1       = '{sym: dec.sym, len: idx};
               d.mc1_vld   = 1'b1;
               d.rd_static = 1'b0;
               load[2]     = 1'b1;
            end
         end
         mct_pkg::MCT_CAPT: begin
            if (sw_rise) begin
               d.st = mct_pkg::MCT_SAVE;
            end
         end
         mct_pkg::MCT_SAVE: begin
            d.st      = mct_pkg::MCT_IDLE;
            d.save    = 1'b1;
            d.cmp_act = 1'b1;
            d.lock    = q.ctrl.teach_static;
            d.clr     = q.ctrl.teach_static & q.ctrl.cnt_rst;
         end
         default: begin
            d.st = mct_pkg::MCT_IDLE;
         end
      endcase

      // Reading interval: own pulse in static teach, external otherwise
      d.rd = d.rd_static | (rd_trig & ~q.rd_static);

      // Comparison and forwarding of each good read
      lock_ok = ~q.lock | ((dec.sym == q.mc1.sym) & (idx == q.mc1.len));
      if (reading && dec.done) begin
         d.fwd = ~ovf & lock_ok & (~q.ctrl.filt_en | m1a | m2a);
         if (cmp_eff) begin
            load = load | fire;
         end
      end

      // Result pulses of configured length
      for (int i = 0; i < 3; i++) begin
         if (load[i]) begin
            d.rcnt[i] = q.pulse_len;
         end else if (q.rcnt[i] != 16'h0000) begin
            d.rcnt[i] = q.rcnt[i] - 16'h0001;
         end
         d.res[i] = (d.rcnt[i] != 16'h0000);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q           <= '0;
         q.ctrl      <= mct_pkg::mct_ctrl_s'(`MCT_RST_CTRL);
         q.pulse_len <= `MCT_RST_PULSE_LEN;
         q.sym_en    <= `MCT_RST_SYM_EN;
         q.mreads    <= `MCT_RST_MREADS;
      end else if (ce) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Code memories
   // ----------------------------------------------------------------
   assign teach_wr = ce & (q.st == mct_pkg::MCT_TEACH) & dec.chr_vld & (idx < `MCT_MAX_LEN);
   assign mc2_wr   = ce & psel & penable & pwrite & (reg_dec(paddr) == 4'h5)
                   & (pwdata[`MCT_MC2_IDX_LSB+5:`MCT_MC2_IDX_LSB] < `MCT_MAX_LEN);

   // Teach writes go to the idle bank, so the old code survives
   always_ff @(posedge pclk) begin
      if (teach_wr) begin
         bank[~q.sel][idx] <= dec.chr;
      end
      if (mc2_wr) begin
         mc2_mem[pwdata[`MCT_MC2_IDX_LSB+5:`MCT_MC2_IDX_LSB]] <= pwdata[7:0];
      end
   end

   // Content readout for the parameter store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_chr <= 8'h00;
      end else if (ce) begin
         nv_chr <= (nv_addr < `MCT_MAX_LEN) ? bank[q.sel][nv_addr] : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata      = q.rdata;
   assign pready      = 1'b1;
   assign pslverr     = psel & penable & (reg_dec(paddr) == 4'h0);
   assign rd_int      = q.rd;
   assign std_dec_sel = q.rd_static;
   assign mreads_req  = q.rd_static ? `MCT_TEACH_MREADS : q.mreads;
   assign sym_lock    = q.lock ? (16'h0001 << q.mc1.sym) : q.sym_en;
   assign code_fwd    = q.fwd;
   assign res1        = q.res[0];
   assign res2        = q.res[1];
   assign beep        = q.res[2];
   assign nv_save     = q.save;
   assign nv_code     = q.mc1;
   assign cnt_clr     = q.clr;

endmodule
`default_nettype wire

// [test/mct_sw_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mct_sw_model (
   // Operator and pin
   input  wire logic pclk,
   input  wire logic closed,
   output logic      sens_sw
);
   // Open at power-up
   initial sens_sw = 1'b0;
   // Contact chatter before the level settles
   always @(closed) begin
      repeat (3) begin
         @(posedge pclk);
         sens_sw <= ~sens_sw;
      end
      @(posedge pclk);
      sens_sw <= closed;
   end
endmodule
`default_nettype wire

// [test/mct_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module mct_chk (
   // Watched ports
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [7:0]        paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire mct_pkg::mct_dec_s dec,
   input wire logic              rd_int,
   input wire logic              std_dec_sel,
   input wire logic [7:0]        mreads_req,
   input wire logic              code_fwd,
   input wire logic              nv_save,
   input wire logic              cnt_clr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_unmapped_err: assert property (psel && penable && paddr > 8'h1C |-> pslverr) else $error("no slverr");
   a_mapped_ok: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("bad slverr");
   a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
   a_teach_reads: assert property (std_dec_sel |-> mreads_req == 8'd30) else $error("reads not 30");
   a_own_pulse: assert property (std_dec_sel |-> rd_int) else $error("no own pulse");
   a_fwd_done: assert property (code_fwd |-> $past(dec.done)) else $error("stray forward");
   a_save_pulse: assert property (nv_save |=> !nv_save) else $error("long save");
   a_clr_on_save: assert property (cnt_clr |-> nv_save) else $error("stray clear");
endmodule
bind mct_teach_ctrl mct_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .dec(dec), .rd_int(rd_int), .std_dec_sel(std_dec_sel),
   .mreads_req(mreads_req), .code_fwd(code_fwd), .nv_save(nv_save), .cnt_clr(cnt_clr));
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, closed = 0, sens_sw;
   logic [7:0]        paddr = 0;
   logic [31:0]       pwdata = 0, prdata, rd;
   logic              pready;
   logic [15:0]       sym_lock;
   logic              code_fwd, res2, beep, nv_save, cnt_clr, rd_trig = 0;
   mct_pkg::mct_dec_s dec = '0;
   int                n_errors = 0, cmp_count = 0, n_fwd = 0, n_save = 0, n_clr = 0;
   always #20 pclk = ~pclk;
   mct_teach_ctrl #(.DEB_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .sens_sw(sens_sw), .dec(dec), .rd_trig(rd_trig), .rd_int(), .std_dec_sel(), .mreads_req(),
      .sym_lock(sym_lock), .code_fwd(code_fwd), .res1(), .res2(res2), .beep(beep), .nv_save(nv_save),
      .nv_code(), .nv_addr(6'h00), .nv_chr(), .cnt_clr(cnt_clr));
   mct_sw_model i_sw (.pclk(pclk), .closed(closed), .sens_sw(sens_sw));
   // Pulse counters for one-cycle outputs
   always @(posedge pclk) begin
      n_fwd  += code_fwd;
      n_save += nv_save;
      n_clr  += cnt_clr;
   end
   // One APB transfer, held until pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
      xfer(1'b0, a, 32'h0);
      chk("register", e, rd & m);
   endtask
   // Decoder stream: start, n characters, good read
   task automatic code(input logic [3:0] s, input int n, input logic [7:0] c);
      @(posedge pclk);
      dec.start <= 1'b1;
      @(posedge pclk);
      dec <= '{start: 0, sym: s, chr_vld: 1, chr: c, done: 0};
      repeat (n) @(posedge pclk);
      dec <= '{start: 0, sym: s, chr_vld: 0, chr: c, done: 1};
      @(posedge pclk);
      dec <= '0;
   endtask
   task automatic sw(input logic c);
      @(posedge pclk);
      closed <= c;
      repeat (30) @(posedge pclk);
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'h14, 32'hFFFF, 32'h0FA0);
      rchk(8'h40, 32'hFFFFFFFF, 32'h0);
      xfer(1'b1, 8'h00, 32'hE8);
      sw(1'b1);
      xfer(1'b1, 8'h00, 32'h2068);
      rchk(8'h04, 32'h07, 32'h04);
      sw(1'b0);
      rchk(8'h04, 32'h13, 32'h11);
      code(4'h2, 3, 8'h1F);
      rchk(8'h04, 32'h03, 32'h01);
      code(4'h2, 3, 8'h41);
      rchk(8'h04, 32'h13, 32'h03);
      chk("beep", 32'h1, beep);
      sw(1'b1);
      rchk(8'h08, 32'h3FF, 32'h083);
      chk("sym_lock", 32'h0004, sym_lock);
      code(4'h2, 3, 8'h41);
      code(4'h3, 3, 8'h41);
      sw(1'b0);
      chk("res2", 32'h1, res2);
      rchk(8'h04, 32'h03, 32'h01);
      sw(1'b1);
      rchk(8'h04, 32'h03, 32'h00);
      rchk(8'h08, 32'h3FF, 32'h083);
      // Dynamic teach: needs the external reading pulse
      xfer(1'b1, 8'h00, 32'h2040);
      sw(1'b0);
      code(4'h5, 4, 8'h42);
      rchk(8'h04, 32'h13, 32'h01);
      rd_trig <= 1'b1;
      code(4'h5, 4, 8'h42);
      rd_trig <= 1'b0;
      rchk(8'h04, 32'h13, 32'h03);
      sw(1'b1);
      rchk(8'h08, 32'h3FF, 32'h144);
      chk("sym_lock", 32'hFFFF, sym_lock);
      chk("forwards", 32'd1, n_fwd);
      chk("saves", 32'd2, n_save);
      chk("clears", 32'd1, n_clr);
      stop_test;
   end
   // Hang guard
   initial begin
      repeat (3000) @(posedge pclk);
      n_errors++;
      stop_test;
   end
endmodule
`default_nettype wire
